// ### src/iolsp_hex_emit.v
`timescale 1ns/1ps
`include "iolsp_regs.vh"
// serialises a value as ascii hex digits followed by a carriage return
module iolsp_hex_emit (
   input  wire        i_mclk,
   input  wire        i_nrst,
   input  wire        i_start,
   input  wire [15:0] i_value,
   input  wire [2:0]  i_ndig,
   input  wire        i_ready,
   output reg         o_busy,
   output reg         o_valid,
   output reg  [7:0]  o_byte
);
   reg [15:0] shreg;
   reg [2:0]  left;

   function [7:0] iolsp_hexch;
      input [3:0] n;
      begin
         iolsp_hexch = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
      end
   endfunction

   always @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         shreg   <= 16'h0000;
         left    <= 3'h0;
         o_busy  <= 1'b0;
         o_valid <= 1'b0;
         o_byte  <= 8'h00;
      end else if (!o_busy) begin
         if (i_ready)
            o_valid <= 1'b0;
         if (i_start) begin
            shreg  <= i_value << {i_ndig == 3'h2 ? 3'h2 : 3'h0, 2'h0};
            left   <= i_ndig;
            o_busy <= 1'b1;
         end
      end else if (!o_valid || i_ready) begin
         o_valid <= 1'b1;
         if (left != 3'h0) begin
            o_byte <= iolsp_hexch(shreg[15:12]);
            shreg  <= {shreg[11:0], 4'h0};
            left   <= left - 3'h1;
         end else if (o_byte != `IOLSP_ASCII_CR || !o_valid) begin
            o_byte <= `IOLSP_ASCII_CR;
            o_busy <= 1'b0;
         end
      end
   end
endmodule

// ### src/iolsp_regs.vh
`ifndef IOLSP_REGS_VH
`define IOLSP_REGS_VH
`define IOLSP_MS_NS          32'd1000000
`define IOLSP_CLK_NS         32'd5
`define IOLSP_MS_CYCLES      (`IOLSP_MS_NS / `IOLSP_CLK_NS)
`define IOLSP_BUF_BYTES      7'd93
`define IOLSP_BUF_SAMPLES    6'd46
`define IOLSP_SPT_RESET      8'h01
`define IOLSP_FWD_RESET      1'b1
`define IOLSP_ADDR_BLOCK     64'hFFFFFFFFFFFFFFFF
`define IOLSP_ADDR_ANY       64'h000000000000FFFF
`define IOLSP_ASCII_CR       8'h0D
`define IOLSP_ASCII_O        8'h4F
`define IOLSP_ASCII_K        8'h4B
`define IOLSP_KIND_PERIODIC  2'h0
`define IOLSP_KIND_CHANGE    2'h1
`define IOLSP_KIND_FORCED    2'h2
`endif

// ### src/iolsp_top.v
`timescale 1ns/1ps
`include "iolsp_regs.vh"
module iolsp_top (
   input  wire        i_mclk,
   input  wire        i_nrst,
   input  wire [15:0] i_sample_interval,
   input  wire [7:0]  i_samples_per_transmit,
   input  wire        i_spt_load,
   input  wire [7:0]  i_change_detect_mask,
   input  wire [63:0] i_bound_input_address,
   input  wire        i_force_sample_cmd,
   input  wire        i_framed_api_select,
   input  wire        i_serial_io_forward_enable,
   input  wire        i_sleep_enable,
   input  wire [7:0]  i_dig_enable,
   input  wire [7:0]  i_dig_is_output,
   input  wire [5:0]  i_adc_enable,
   input  wire [7:0]  i_digital_line,
   input  wire [7:0]  i_out_level,
   input  wire        i_out_level_wr,
   output reg         o_adc_start,
   output reg  [2:0]  o_adc_chan,
   input  wire        i_adc_done,
   input  wire [9:0]  i_adc_data,
   input  wire        i_rx_io_valid,
   input  wire [63:0] i_rx_io_src,
   input  wire [7:0]  i_rx_io_levels,
   output reg         o_fwd_valid,
   output reg  [7:0]  o_fwd_levels,
   output reg  [7:0]  o_line_out,
   output reg         o_tx_valid,
   output reg  [7:0]  o_tx_byte,
   output reg         o_tx_last,
   output reg  [1:0]  o_tx_kind,
   input  wire        i_tx_ready,
   output reg         o_ser_valid,
   output reg  [7:0]  o_ser_byte,
   output reg         o_ser_frame,
   input  wire        i_ser_ready,
   output reg         o_stay_awake
);
   localparam [3:0] S_IDLE = 4'h0, S_DIG = 4'h1, S_ADC = 4'h2, S_WAIT = 4'h3,
                    S_STORE = 4'h4, S_TX = 4'h5, S_CHG = 4'h6, S_OK = 4'h7,
                    S_TCNT = 4'h8, S_TMSK = 4'h9, S_TDIG = 4'hA, S_TADC = 4'hB,
                    S_TEND = 4'hC, S_HEXW = 4'hD;
   localparam [31:0] MS_CYC = `IOLSP_MS_CYCLES;
   reg [3:0]  state;
   reg [3:0]  ret_state;
   reg [17:0] ms_cnt;
   reg [15:0] int_cnt;
   reg        tick_pend;
   reg [7:0]  spt;
   reg [7:0]  prev_lines;
   reg        chg_pend;
   reg        force_pend;
   reg        primed;
   reg [1:0]  kind;
   reg [7:0]  buf_mem [0:92];
   reg [6:0]  wr_ptr;
   reg [6:0]  rd_ptr;
   reg [5:0]  nsamp;
   reg [7:0]  cur_dig;
   reg [9:0]  adc_val [0:5];
   reg [2:0]  ch;
   reg [15:0] hex_val;
   reg [2:0]  hex_nd;
   reg        hex_go;
   reg        ok_step;
   wire       hex_busy;
   wire       hex_valid;
   wire [7:0] hex_byte;
   integer    k;
   function [2:0] iolsp_next_ch;
      input [5:0] en;
      input [2:0] from;
      integer j;
      begin
         iolsp_next_ch = 3'h6;
         for (j = 5; j >= 0; j = j - 1)
            if (en[j] && j >= from)
               iolsp_next_ch = j[2:0];
      end
   endfunction
   function [6:0] iolsp_sample_bytes;
      input [5:0] en;
      input       dig_only;
      integer j;
      begin
         iolsp_sample_bytes = 7'h01;
         if (!dig_only)
            for (j = 0; j < 6; j = j + 1)
               if (en[j])
                  iolsp_sample_bytes = iolsp_sample_bytes + 7'h02;
      end
   endfunction
   wire [7:0] changed   = (i_digital_line ^ prev_lines) & i_change_detect_mask & {8{primed}};
   wire       addr_ok   = (i_bound_input_address != `IOLSP_ADDR_BLOCK) &&
                          ((i_bound_input_address == `IOLSP_ADDR_ANY) ||
                           (i_rx_io_src == i_bound_input_address));
   wire [6:0] samp_len  = iolsp_sample_bytes(i_adc_enable, kind == `IOLSP_KIND_CHANGE);
   wire       buf_room  = ({1'b0, wr_ptr} + {1'b0, samp_len}) <= {1'b0, `IOLSP_BUF_BYTES} &&
                          nsamp < `IOLSP_BUF_SAMPLES;
   iolsp_hex_emit u_hex (
      .i_mclk  (i_mclk),
      .i_nrst  (i_nrst),
      .i_start (hex_go),
      .i_value (hex_val),
      .i_ndig  (hex_nd),
      .i_ready (state == S_HEXW && (!o_ser_valid || i_ser_ready)),
      .o_busy  (hex_busy),
      .o_valid (hex_valid),
      .o_byte  (hex_byte)
   );
   always @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         ms_cnt    <= 18'h00000;
         int_cnt   <= 16'h0000;
         tick_pend <= 1'b0;
      end else begin
         if (state == S_IDLE && !chg_pend && !force_pend && tick_pend)
            tick_pend <= 1'b0;
         if (i_sample_interval == 16'h0000) begin
            ms_cnt  <= 18'h00000;
            int_cnt <= 16'h0000;
         end else if (ms_cnt == MS_CYC[17:0] - 18'h1) begin
            ms_cnt <= 18'h00000;
            if (int_cnt >= i_sample_interval - 16'h1) begin
               int_cnt   <= 16'h0000;
               tick_pend <= 1'b1;
            end else begin
               int_cnt <= int_cnt + 16'h1;
            end
         end else begin
            ms_cnt <= ms_cnt + 18'h1;
         end
      end
   end
   always @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_line_out   <= 8'h00;
         o_fwd_valid  <= 1'b0;
         o_fwd_levels <= 8'h00;
         spt          <= `IOLSP_SPT_RESET;
      end else begin
         if (i_out_level_wr)
            o_line_out <= (o_line_out & ~i_dig_is_output) | (i_out_level & i_dig_is_output);
         else if (i_rx_io_valid && addr_ok)
            o_line_out <= (o_line_out & ~i_dig_is_output) |
                          (i_rx_io_levels & i_dig_is_output);
         o_fwd_valid  <= i_rx_io_valid && i_serial_io_forward_enable;
         if (i_rx_io_valid)
            o_fwd_levels <= i_rx_io_levels;
         if (i_spt_load && i_samples_per_transmit != 8'h00)
            spt <= i_samples_per_transmit;
      end
   end
   always @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         state        <= S_IDLE;
         ret_state    <= S_IDLE;
         prev_lines   <= 8'h00;
         primed       <= 1'b0;
         chg_pend     <= 1'b0;
         force_pend   <= 1'b0;
         kind         <= `IOLSP_KIND_PERIODIC;
         wr_ptr       <= 7'h00;
         rd_ptr       <= 7'h00;
         nsamp        <= 6'h00;
         cur_dig      <= 8'h00;
         ch           <= 3'h0;
         hex_val      <= 16'h0000;
         hex_nd       <= 3'h0;
         hex_go       <= 1'b0;
         ok_step      <= 1'b0;
         o_adc_start  <= 1'b0;
         o_adc_chan   <= 3'h0;
         o_tx_valid   <= 1'b0;
         o_tx_byte    <= 8'h00;
         o_tx_last    <= 1'b0;
         o_tx_kind    <= 2'h0;
         o_ser_valid  <= 1'b0;
         o_ser_byte   <= 8'h00;
         o_ser_frame  <= 1'b0;
         o_stay_awake <= 1'b0;
         for (k = 0; k < 93; k = k + 1)
            buf_mem[k] <= 8'h00;
         for (k = 0; k < 6; k = k + 1)
            adc_val[k] <= 10'h000;
      end else begin
         prev_lines  <= i_digital_line;
         primed      <= 1'b1;
         o_adc_start <= 1'b0;
         hex_go      <= 1'b0;
         if (changed != 8'h00)
            chg_pend <= 1'b1;
         if (i_force_sample_cmd)
            force_pend <= 1'b1;
         o_stay_awake <= i_sleep_enable && (i_sample_interval != 16'h0000) &&
                         (nsamp != 6'h00 || state != S_IDLE);
         if (o_ser_valid && i_ser_ready)
            o_ser_valid <= 1'b0;
         case (state)
            S_IDLE: begin
               if (chg_pend) begin
                  kind <= (nsamp != 6'h00) ? kind : `IOLSP_KIND_CHANGE;
                  state <= (nsamp != 6'h00) ? S_TX : S_DIG;
                  ret_state <= (nsamp != 6'h00) ? S_CHG : S_IDLE;
               end else if (force_pend) begin
                  force_pend <= i_force_sample_cmd;
                  kind  <= `IOLSP_KIND_FORCED;
                  state <= i_framed_api_select ? S_OK : S_DIG;
                  ok_step <= 1'b0;
               end else if (tick_pend) begin
                  kind  <= `IOLSP_KIND_PERIODIC;
                  state <= S_DIG;
               end
            end
            S_CHG: begin
               kind  <= `IOLSP_KIND_CHANGE;
               state <= S_DIG;
            end
            S_OK: begin
               if (!o_ser_valid || i_ser_ready) begin
                  o_ser_valid <= 1'b1;
                  o_ser_frame <= 1'b1;
                  o_ser_byte  <= ok_step ? `IOLSP_ASCII_K : `IOLSP_ASCII_O;
                  ok_step     <= 1'b1;
                  if (ok_step)
                     state <= S_DIG;
               end
            end
            S_DIG: begin
               cur_dig <= i_digital_line & i_dig_enable;
               if (kind == `IOLSP_KIND_CHANGE) begin
                  chg_pend <= (changed != 8'h00);
                  state    <= S_STORE;
               end else begin
                  ch    <= iolsp_next_ch(i_adc_enable, 3'h0);
                  state <= S_ADC;
               end
            end
            S_ADC: begin
               if (ch == 3'h6) begin
                  state <= (kind == `IOLSP_KIND_FORCED && !i_framed_api_select) ?
                           S_TCNT : S_STORE;
               end else begin
                  o_adc_start <= 1'b1;
                  o_adc_chan  <= ch;
                  state       <= S_WAIT;
               end
            end
            S_WAIT: begin
               if (i_adc_done) begin
                  adc_val[ch] <= i_adc_data;
                  ch    <= iolsp_next_ch(i_adc_enable, ch + 3'h1);
                  state <= S_ADC;
               end
            end
            S_STORE: begin
               if (buf_room) begin
                  buf_mem[wr_ptr] <= cur_dig;
                  if (kind != `IOLSP_KIND_CHANGE)
                     for (k = 0; k < 6; k = k + 1)
                        if (i_adc_enable[k]) begin
                           buf_mem[wr_ptr + iolsp_sample_bytes(i_adc_enable &
                              ((6'h01 << k) - 6'h01), 1'b0)] <= {6'h00, adc_val[k][9:8]};
                           buf_mem[wr_ptr + 7'h1 + iolsp_sample_bytes(i_adc_enable &
                              ((6'h01 << k) - 6'h01), 1'b0)] <= adc_val[k][7:0];
                        end
                  wr_ptr <= wr_ptr + samp_len;
                  nsamp  <= nsamp + 6'h1;
               end
               // pass on at count; change sent alone
               if (kind != `IOLSP_KIND_PERIODIC || {2'b00, nsamp} + 8'h1 >= spt ||
                   !buf_room)
                  state <= S_TX;
               else
                  state <= S_IDLE;
            end
            S_TX: begin
               if (!o_tx_valid || i_tx_ready) begin
                  if (rd_ptr == wr_ptr) begin
                     o_tx_valid <= 1'b0;
                     rd_ptr <= 7'h00;
                     wr_ptr <= 7'h00;
                     nsamp  <= 6'h00;
                     o_ser_frame <= 1'b0;
                     state  <= ret_state;
                     ret_state <= S_IDLE;
                  end else begin
                     o_tx_valid <= 1'b1;
                     o_tx_byte  <= buf_mem[rd_ptr];
                     o_tx_last  <= (rd_ptr + 7'h1 == wr_ptr);
                     o_tx_kind  <= kind;
                     rd_ptr     <= rd_ptr + 7'h1;
                  end
               end
            end
            S_TCNT: begin
               hex_val <= 16'h0001;
               hex_nd  <= 3'h2;
               hex_go  <= 1'b1;
               ret_state <= S_TMSK;
               state   <= S_HEXW;
            end
            S_TMSK: begin
               hex_val <= {2'b00, i_adc_enable, i_dig_enable};
               hex_nd  <= 3'h4;
               hex_go  <= 1'b1;
               ret_state <= (i_dig_enable != 8'h00) ? S_TDIG : S_TADC;
               ch      <= iolsp_next_ch(i_adc_enable, 3'h0);
               state   <= S_HEXW;
            end
            S_TDIG: begin
               hex_val <= {8'h00, cur_dig};
               hex_nd  <= 3'h4;
               hex_go  <= 1'b1;
               ret_state <= S_TADC;
               state   <= S_HEXW;
            end
            S_TADC: begin
               if (ch == 3'h6) begin
                  state <= S_TEND;
               end else begin
                  hex_val <= {6'h00, adc_val[ch]};
                  hex_nd  <= 3'h4;
                  hex_go  <= 1'b1;
                  ch      <= iolsp_next_ch(i_adc_enable, ch + 3'h1);
                  ret_state <= S_TADC;
                  state   <= S_HEXW;
               end
            end
            S_HEXW: begin
               o_ser_frame <= 1'b0;
               if (!hex_go && !hex_busy && !hex_valid)
                  state <= ret_state;
               else if (hex_valid && (!o_ser_valid || i_ser_ready)) begin
                  o_ser_valid <= 1'b1;
                  o_ser_byte  <= hex_byte;
               end
            end
            S_TEND: begin
               if (!o_ser_valid || i_ser_ready) begin
                  o_ser_valid <= 1'b1;
                  o_ser_byte  <= `IOLSP_ASCII_CR;
                  ret_state   <= S_IDLE;
                  state       <= S_IDLE;
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end
endmodule

// ### test/iolsp_partner.sv
`timescale 1ns/1ps
module iolsp_partner (
   input  wire        i_mclk,
   input  wire        i_nrst,
   input  wire        i_slow,
   input  wire        i_adc_start,
   input  wire [2:0]  i_adc_chan,
   output logic       o_adc_done,
   output logic [9:0] o_adc_data,
   input  wire        i_tx_valid,
   input  wire [7:0]  i_tx_byte,
   input  wire        i_tx_last,
   input  wire [1:0]  i_tx_kind,
   output logic       o_tx_ready,
   input  wire        i_ser_valid,
   input  wire [7:0]  i_ser_byte,
   input  wire        i_ser_frame,
   output logic       o_ser_ready
);
   logic [10:0] tx_q[$];
   logic [8:0]  ser_q[$];
   int          adc_n = 0;
   int          wait_cnt = 0;
   logic [2:0]  chan = 3'h0;
   logic        ph = 1'h0;
   initial o_adc_data = 10'h155;
   always @(posedge i_mclk) begin
      if (i_tx_valid && o_tx_ready) tx_q.push_back({i_tx_kind, i_tx_last, i_tx_byte});
      if (i_ser_valid && o_ser_ready) ser_q.push_back({i_ser_frame, i_ser_byte});
   end
   // converter answers late; data bus toggles while idle
   always @(negedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         wait_cnt <= 0;
         o_adc_done <= 1'h0;
         o_tx_ready <= 1'h0;
         o_ser_ready <= 1'h0;
      end else begin
         ph <= ~ph;
         o_tx_ready <= !i_slow || ph;
         o_ser_ready <= !i_slow || ph;
         o_adc_done <= (wait_cnt == 1);
         o_adc_data <= (wait_cnt == 1) ? (10'h120 | {7'h00, chan}) : ~o_adc_data;
         if (i_adc_start) begin
            chan <= i_adc_chan;
            wait_cnt <= 4;
            adc_n <= adc_n + 1;
         end else if (wait_cnt != 0) begin
            wait_cnt <= wait_cnt - 1;
         end
      end
   end
endmodule

// ### test/iolsp_top_bench.sv
`timescale 1ns/1ps
`include "iolsp_regs.vh"
module iolsp_top_bench;
   typedef struct packed {
      logic        rx;
      logic [63:0] addr;
      logic [63:0] src;
      logic [7:0]  lvl;
      logic        fwd_en;
      logic [7:0]  exp_line;
      logic        chk_fwd;
      logic        exp_fwd;
   } iolsp_row_t;
   logic        i_mclk = 1'h0, i_nrst = 1'h0, slow = 1'h0;
   logic [15:0] i_sample_interval = 16'h0000;
   logic [7:0]  i_samples_per_transmit = 8'h01, i_change_detect_mask = 8'h00;
   logic [7:0]  i_dig_enable = 8'h01, i_dig_is_output = 8'h0F, i_digital_line = 8'h00;
   logic [7:0]  i_out_level = 8'h00, i_rx_io_levels = 8'h00, fl;
   logic [63:0] i_bound_input_address = 64'h0, i_rx_io_src = 64'h0;
   logic [5:0]  i_adc_enable = 6'h04;
   logic        i_spt_load = 1'h0, i_force_sample_cmd = 1'h0, i_framed_api_select = 1'h0;
   logic        i_serial_io_forward_enable = 1'h1, i_sleep_enable = 1'h0, fv;
   logic        i_out_level_wr = 1'h0, i_rx_io_valid = 1'h0;
   wire         o_adc_start, i_adc_done, o_fwd_valid, o_tx_valid, o_tx_last, i_tx_ready;
   wire         o_ser_valid, o_ser_frame, i_ser_ready, o_stay_awake;
   wire [2:0]   o_adc_chan;
   wire [9:0]   i_adc_data;
   wire [7:0]   o_fwd_levels, o_line_out, o_tx_byte, o_ser_byte;
   wire [1:0]   o_tx_kind;
   iolsp_row_t  rows[7];
   logic [7:0]  exp_txt[19];
   int          num_errors = 0, n_checks = 0, cycles = 0, r, n0;
   iolsp_top i_dut (.*);
   iolsp_partner p (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_slow(slow),
      .i_adc_start(o_adc_start), .i_adc_chan(o_adc_chan), .o_adc_done(i_adc_done),
      .o_adc_data(i_adc_data), .i_tx_valid(o_tx_valid), .i_tx_byte(o_tx_byte),
      .i_tx_last(o_tx_last), .i_tx_kind(o_tx_kind), .o_tx_ready(i_tx_ready),
      .i_ser_valid(o_ser_valid), .i_ser_byte(o_ser_byte), .i_ser_frame(o_ser_frame),
      .o_ser_ready(i_ser_ready));
   always #2.5 i_mclk = ~i_mclk;
   task check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task print_verdict();
      $display("checks=%0d errors=%0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge i_mclk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         print_verdict();
      end
   end
   task do_reset();
      @(negedge i_mclk);
      i_nrst = 1'h0;
      repeat (4) @(negedge i_mclk);
      check({o_tx_valid, o_ser_valid, o_fwd_valid, o_adc_start, o_line_out}, 16'h0000);
      i_nrst = 1'h1;
      @(negedge i_mclk);
      check({o_tx_valid, o_ser_valid, o_fwd_valid, o_adc_start, o_line_out}, 16'h0000);
   endtask
   task pulse_force();
      @(negedge i_mclk);
      i_force_sample_cmd = 1'h1;
      @(negedge i_mclk);
      i_force_sample_cmd = 1'h0;
   endtask
   task wait_q(input int n, input logic tx);
      int k;
      for (k = 0; k < 4000; k++) begin
         if ((tx ? p.tx_q.size() : p.ser_q.size()) >= n) break;
         @(negedge i_mclk);
      end
      repeat (60) @(negedge i_mclk);
   endtask
   initial begin
      rows[0] = '{1'h0, 64'h0, 64'h0, 8'hFF, 1'h1, 8'h0F, 1'h0, 1'h0};
      rows[1] = '{1'h0, 64'h0, 64'h0, 8'h05, 1'h1, 8'h05, 1'h0, 1'h0};
      rows[2] = '{1'h1, 64'h1234, 64'h1234, 8'h0A, 1'h1, 8'h0A, 1'h1, 1'h1};
      rows[3] = '{1'h1, 64'h1234, 64'h1235, 8'h0F, 1'h1, 8'h0A, 1'h0, 1'h0};
      rows[4] = '{1'h1, `IOLSP_ADDR_BLOCK, `IOLSP_ADDR_BLOCK, 8'h03, 1'h1, 8'h0A, 1'h0, 1'h0};
      rows[5] = '{1'h1, `IOLSP_ADDR_ANY, 64'h0102030405060708, 8'h06, 1'h0, 8'h06, 1'h1, 1'h0};
      rows[6] = '{1'h1, 64'h0102030405060708, 64'h0102030405060708, 8'hF9, 1'h1, 8'h09,
                  1'h1, 1'h1};
      exp_txt = '{8'h30, 8'h31, 8'h0D, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0D, 8'h30, 8'h30,
                  8'h30, 8'h30, 8'h0D, 8'h30, 8'h31, 8'h32, 8'h32, 8'h0D, 8'h0D};
      do_reset();
      for (r = 0; r < 7; r++) begin
         @(negedge i_mclk);
         i_bound_input_address = rows[r].addr;
         i_serial_io_forward_enable = rows[r].fwd_en;
         i_rx_io_src = rows[r].src;
         i_rx_io_levels = rows[r].lvl;
         i_out_level = rows[r].lvl;
         @(negedge i_mclk);
         if (rows[r].rx) i_rx_io_valid = 1'h1;
         else i_out_level_wr = 1'h1;
         @(negedge i_mclk);
         i_rx_io_valid = 1'h0;
         i_out_level_wr = 1'h0;
         fv = o_fwd_valid;
         fl = o_fwd_levels;
         repeat (3) @(negedge i_mclk);
         check(o_line_out, rows[r].exp_line);
         if (rows[r].chk_fwd) check(fv, rows[r].exp_fwd);
         if (rows[r].exp_fwd) check(fl, rows[r].lvl);
      end
      slow = 1'h1;
      pulse_force();
      wait_q(19, 1'h0);
      for (r = 0; r < 19; r++) if (exp_txt[r] != 8'h00) check(p.ser_q[r][7:0], exp_txt[r]);
      check(p.ser_q.size(), 16'd19);
      p.ser_q.delete();
      i_framed_api_select = 1'h1;
      pulse_force();
      wait_q(3, 1'h1);
      check(p.ser_q[0], {1'h1, `IOLSP_ASCII_O});
      check(p.ser_q[1], {1'h1, `IOLSP_ASCII_K});
      for (r = 0; r < 3; r++) check(p.tx_q[r][10:8], {`IOLSP_KIND_FORCED, r == 2});
      check(p.tx_q.size(), 16'd3);
      check(p.tx_q[0][7:0], 8'h00);
      check(p.tx_q[1][7:0], 8'h01);
      check(p.tx_q[2][7:0], 8'h22);
      p.tx_q.delete();
      i_framed_api_select = 1'h0;
      i_change_detect_mask = 8'h01;
      repeat (20) @(negedge i_mclk);
      i_digital_line = 8'h02;
      repeat (200) @(negedge i_mclk);
      check(p.tx_q.size(), 16'd0);
      i_digital_line = 8'h03;
      wait_q(1, 1'h1);
      check(p.tx_q[0][10:8], {`IOLSP_KIND_CHANGE, 1'h1});
      check(p.tx_q.size(), 16'd1);
      i_sleep_enable = 1'h1;
      i_samples_per_transmit = 8'h02;
      i_spt_load = 1'h1;
      @(negedge i_mclk);
      i_spt_load = 1'h0;
      // host sets interval to 20 ms for the stay-awake check, then clears it
      i_sample_interval = 16'h0014;
      pulse_force();
      repeat (4) @(negedge i_mclk);
      check(o_stay_awake, 1'h1);
      i_sample_interval = 16'h0000;
      i_sleep_enable = 1'h0;
      repeat (100) @(negedge i_mclk);
      p.tx_q.delete();
      n0 = p.adc_n;
      repeat (1000) @(negedge i_mclk);
      check(p.adc_n - n0, 16'd0);
      check(p.tx_q.size(), 16'd0);
      do_reset();
      print_verdict();
   end
endmodule

// ### test/iolsp_top_properties.sv
`timescale 1ns/1ps
`include "iolsp_regs.vh"
module iolsp_top_properties (
   input logic        i_mclk,
   input logic        i_nrst,
   input logic        i_force_sample_cmd,
   input logic        i_serial_io_forward_enable,
   input logic [63:0] i_bound_input_address,
   input logic [7:0]  i_dig_is_output,
   input logic [5:0]  i_adc_enable,
   input logic        i_out_level_wr,
   input logic        i_rx_io_valid,
   input logic [63:0] i_rx_io_src,
   input logic [7:0]  i_rx_io_levels,
   input logic        o_adc_start,
   input logic [2:0]  o_adc_chan,
   input logic        o_fwd_valid,
   input logic [7:0]  o_fwd_levels,
   input logic [7:0]  o_line_out,
   input logic        o_tx_valid,
   input logic [7:0]  o_tx_byte,
   input logic        o_tx_last,
   input logic [1:0]  o_tx_kind,
   input logic        i_tx_ready,
   input logic        o_ser_valid,
   input logic [7:0]  o_ser_byte,
   input logic        o_ser_frame,
   input logic        i_ser_ready
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);
   a_rst_quiet: assert property ($rose(i_nrst) |-> !o_tx_valid && !o_ser_valid
      && !o_fwd_valid && !o_adc_start && o_line_out == 8'h00) else $error("outputs not idle");
   a_tx_hold: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid
      && $stable({o_tx_byte, o_tx_last, o_tx_kind})) else $error("tx byte dropped");
   a_ser_hold: assert property (o_ser_valid && !i_ser_ready |=> o_ser_valid
      && $stable({o_ser_byte, o_ser_frame})) else $error("serial byte dropped");
   a_line_mask: assert property (((o_line_out ^ $past(o_line_out))
      & ~$past(i_dig_is_output)) == 8'h00) else $error("non-output line changed");
   a_block_addr: assert property ($past(i_bound_input_address) == `IOLSP_ADDR_BLOCK
      && !$past(i_out_level_wr) |-> $stable(o_line_out)) else $error("blocked packet applied");
   a_rx_match: assert property ($past(i_rx_io_valid)
      && $past(i_rx_io_src) == $past(i_bound_input_address)
      && $past(i_bound_input_address) != `IOLSP_ADDR_BLOCK && !$past(i_out_level_wr)
      |-> o_line_out == (($past(o_line_out) & ~$past(i_dig_is_output))
      | ($past(i_rx_io_levels) & $past(i_dig_is_output)))) else $error("rx levels wrong");
   a_fwd_cause: assert property (o_fwd_valid |-> $past(i_rx_io_valid)
      && $past(i_serial_io_forward_enable) && o_fwd_levels == $past(i_rx_io_levels))
      else $error("forward without cause");
   a_chg_dig_only: assert property (o_tx_valid && o_tx_kind == `IOLSP_KIND_CHANGE
      |-> o_tx_last) else $error("change sample too long");
   a_adc_enabled: assert property (o_adc_start |-> i_adc_enable[o_adc_chan])
      else $error("disabled channel converted");
   a_adc_prompt: assert property (i_force_sample_cmd && i_adc_enable != 6'h00
      |-> ##[1:20] o_adc_start) else $error("force sample not started");
endmodule
bind iolsp_top iolsp_top_properties i_props (.*);
